// File: imc_pkg.sv
// register map, field positions and sequence states of the serial port
// assumes a 32-bit apb slave with byte addressing and one word per register
package imc_pkg;

  // ==========================================================================
  // bus and register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_RELOAD = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SHBUF = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CON1 = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CON2 = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CON3 = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_COLL = 8'h1C;

  // ==========================================================================
  // field positions
  localparam int CON1_WCOL_BIT = 7;
  localparam int CON1_ENABLE_BIT = 5;
  localparam int CON2_STOP_EN_BIT = 2;
  localparam int CON2_RESTART_EN_BIT = 1;
  localparam int STAT_HI_LSB = 6;
  localparam int COLL_FLAG_BIT = 0;
  localparam int COLL_BUSY_BIT = 1;

  // ==========================================================================
  // reset values and counts
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;
  localparam int BYTE_BITS = 8;

  // ==========================================================================
  // sequence states
  typedef enum logic [3:0] {
    IMC_IDLE       = 4'h0,
    IMC_RS_SDA_REL = 4'h1,
    IMC_RS_WAIT1   = 4'h2,
    IMC_RS_SCL_REL = 4'h3,
    IMC_RS_WAIT2   = 4'h4,
    IMC_RS_WAIT3   = 4'h5,
    IMC_ST_SDA_LOW = 4'h6,
    IMC_ST_SCL_REL = 4'h7,
    IMC_ST_WAIT1   = 4'h8,
    IMC_ST_WAIT2   = 4'h9,
    IMC_ST_WAIT3   = 4'hA,
    IMC_TX_LOW     = 4'hB,
    IMC_TX_HIGH    = 4'hC
  } imc_state_e;

endpackage

// File: imc_rate_counter.sv
// rate counter: a down counter that times one half period of the bus clock
// assumes the owner pulses i_load to start or reload and reads o_expire
`timescale 1ns/1ps
`default_nettype none
module imc_rate_counter
  import imc_pkg::*;
#(
  parameter int RELOAD_W = REG_W
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic i_stop,
  input wire logic [RELOAD_W-1:0] i_reload,
  output logic o_expire,
  output logic o_running
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic run;
    logic [RELOAD_W:0] cnt;
  } imc_brg_s;

  imc_brg_s s;
  imc_brg_s next_s;

  // one rollover lasts 2*(reload+1) clocks, two per bus clock period
  always_comb begin
    next_s = s;
    if (i_stop) begin
      next_s.run = 1'b0;
    end else if (i_load) begin
      next_s.cnt = {i_reload, 1'b1};
      next_s.run = 1'b1;
    end else if (s.run) begin
      if (s.cnt == '0) begin
        next_s.run = 1'b0;
      end else begin
        next_s.cnt = s.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_expire = s.run && (s.cnt == '0);
  assign o_running = s.run;

  // ==========================================================================
  // checks
  logic [RELOAD_W+1:0] chk_elapsed;
  logic [RELOAD_W-1:0] chk_reload;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      chk_elapsed <= '0;
      chk_reload <= '0;
    end else if (i_load) begin
      chk_elapsed <= '0;
      chk_reload <= i_reload;
    end else begin
      chk_elapsed <= chk_elapsed + 1'b1;
    end
  end

  property p_rollover_len;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      o_expire |-> (chk_elapsed == {1'b0, chk_reload, 1'b1});
  endproperty
  a_rollover_len: assert property (p_rollover_len)
    else $error("rollover length is not twice reload plus one");

endmodule
`default_nettype wire

// File: imc_port.sv
// i2c master port: repeated start and stop with collision checks, a byte
// clocker driven by the rate counter, and the apb register file
// assumes open-drain pins resolved outside; pins are asynchronous inputs
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module imc_port
  import imc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  output logic [DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe
);

  // ==========================================================================
  // state
  typedef struct packed {
    imc_state_e st;
    logic [1:0] sda_sy;
    logic [1:0] scl_sy;
    logic sda_lo;
    logic scl_lo;
    logic [REG_W-1:0] reload;
    logic [REG_W-1:0] shbuf;
    logic [REG_W-1:0] sreg;
    logic [REG_W-1:0] con1;
    logic [REG_W-1:0] con2;
    logic [REG_W-1:0] con3;
    logic [REG_W-1:0] mask;
    logic [1:0] stat_hi;
    logic stop_seen;
    logic rs_seen;
    logic bf;
    logic coll;
    logic [3:0] bitcnt;
    logic [DATA_W-1:0] rdata;
  } imc_port_s;

  imc_port_s s;
  imc_port_s next_s;

  logic sda;
  logic scl;
  logic enable;
  logic brg_load;
  logic brg_stop;
  logic brg_expire;
  logic brg_running;
  logic abort;
  logic acc;
  logic acc_wr;
  logic mapped;
  logic busy;

  assign sda = s.sda_sy[1];
  assign scl = s.scl_sy[1];
  assign enable = s.con1[CON1_ENABLE_BIT];
  assign busy = (s.st != IMC_IDLE);
  assign acc = i_psel && i_penable;
  assign acc_wr = acc && i_pwrite;

  // ==========================================================================
  // rate counter
  imc_rate_counter #(
    .RELOAD_W(REG_W)
  ) u_rate_counter (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(brg_load),
    .i_stop(brg_stop),
    .i_reload(s.reload),
    .o_expire(brg_expire),
    .o_running(brg_running)
  );

  // ==========================================================================
  // address decode
  always_comb begin
    case (i_paddr)
      ADDR_RELOAD, ADDR_SHBUF, ADDR_CON1, ADDR_CON2,
      ADDR_CON3, ADDR_MASK, ADDR_STAT, ADDR_COLL: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_s = s;
    brg_load = 1'b0;
    brg_stop = 1'b0;
    abort = 1'b0;
    next_s.sda_sy = {s.sda_sy[0], i_sda};
    next_s.scl_sy = {s.scl_sy[0], i_scl};

    // sequences
    case (s.st)
      IMC_IDLE: begin
        if (enable && s.con2[CON2_RESTART_EN_BIT]) begin
          next_s.sda_lo = 1'b0;
          next_s.scl_lo = 1'b1;
          next_s.st = IMC_RS_SDA_REL;
        end else if (enable && s.con2[CON2_STOP_EN_BIT]) begin
          next_s.sda_lo = 1'b1;
          next_s.st = IMC_ST_SDA_LOW;
        end
      end
      IMC_RS_SDA_REL: begin
        if (sda) begin
          brg_load = 1'b1;
          next_s.st = IMC_RS_WAIT1;
        end
      end
      IMC_RS_WAIT1: begin
        if (brg_expire) begin
          next_s.scl_lo = 1'b0;
          next_s.st = IMC_RS_SCL_REL;
        end
      end
      IMC_RS_SCL_REL: begin
        if (scl) begin
          if (!sda) begin
            abort = 1'b1;
          end else begin
            brg_load = 1'b1;
            next_s.st = IMC_RS_WAIT2;
          end
        end
      end
      IMC_RS_WAIT2: begin
        // a data fall here is another master's start, not a collision
        if (!scl) begin
          abort = 1'b1;
        end else if (brg_expire) begin
          next_s.sda_lo = 1'b1;
          brg_load = 1'b1;
          next_s.st = IMC_RS_WAIT3;
        end
      end
      IMC_RS_WAIT3: begin
        if (brg_expire) begin
          next_s.scl_lo = 1'b1;
          next_s.con2[CON2_RESTART_EN_BIT] = 1'b0;
          next_s.rs_seen = 1'b1;
          next_s.stop_seen = 1'b0;
          next_s.st = IMC_IDLE;
        end
      end
      IMC_ST_SDA_LOW: begin
        if (!sda) begin
          next_s.scl_lo = 1'b0;
          next_s.st = IMC_ST_SCL_REL;
        end
      end
      IMC_ST_SCL_REL: begin
        if (scl) begin
          brg_load = 1'b1;
          next_s.st = IMC_ST_WAIT1;
        end
      end
      IMC_ST_WAIT1: begin
        if (!scl) begin
          abort = 1'b1;
        end else if (brg_expire) begin
          next_s.sda_lo = 1'b0;
          brg_load = 1'b1;
          next_s.st = IMC_ST_WAIT2;
        end
      end
      IMC_ST_WAIT2: begin
        if (!scl && !sda) begin
          abort = 1'b1;
        end else if (brg_expire) begin
          if (!sda) begin
            abort = 1'b1;
          end else begin
            next_s.stop_seen = 1'b1;
            next_s.rs_seen = 1'b0;
            brg_load = 1'b1;
            next_s.st = IMC_ST_WAIT3;
          end
        end
      end
      IMC_ST_WAIT3: begin
        if (brg_expire) begin
          next_s.con2[CON2_STOP_EN_BIT] = 1'b0;
          next_s.st = IMC_IDLE;
        end
      end
      IMC_TX_LOW: begin
        if (brg_expire) begin
          next_s.scl_lo = 1'b0;
          brg_load = 1'b1;
          next_s.st = IMC_TX_HIGH;
        end
      end
      IMC_TX_HIGH: begin
        if (brg_expire) begin
          next_s.bitcnt = s.bitcnt + 4'h1;
          if (s.bitcnt == 4'(BYTE_BITS - 1)) begin
            // no reload: counter stops, clock stays released
            next_s.sda_lo = 1'b0;
            next_s.bf = 1'b0;
            next_s.st = IMC_IDLE;
          end else begin
            next_s.scl_lo = 1'b1;
            next_s.sda_lo = ~s.sreg[REG_W-2];
            next_s.sreg = {s.sreg[REG_W-2:0], 1'b0};
            brg_load = 1'b1;
            next_s.st = IMC_TX_LOW;
          end
        end
      end
      default: begin
        next_s.st = IMC_IDLE;
      end
    endcase

    // register reads are captured in the setup cycle
    if (i_psel && !i_penable) begin
      case (i_paddr)
        ADDR_RELOAD: next_s.rdata = {24'h000000, s.reload};
        ADDR_SHBUF: next_s.rdata = {24'h000000, s.shbuf};
        ADDR_CON1: next_s.rdata = {24'h000000, s.con1};
        ADDR_CON2: next_s.rdata = {24'h000000, s.con2};
        ADDR_CON3: next_s.rdata = {24'h000000, s.con3};
        ADDR_MASK: next_s.rdata = {24'h000000, s.mask};
        ADDR_STAT: begin
          next_s.rdata = {24'h000000, s.stat_hi, 1'b0, s.stop_seen,
                          s.rs_seen, 2'b00, s.bf};
        end
        ADDR_COLL: next_s.rdata = {30'h0, busy, s.coll};
        default: next_s.rdata = WORD_ZERO;
      endcase
    end

    // register writes take effect at the access edge
    if (acc_wr) begin
      case (i_paddr)
        ADDR_RELOAD: next_s.reload = i_pwdata[REG_W-1:0];
        ADDR_SHBUF: begin
          if (!busy && enable && !s.con2[CON2_RESTART_EN_BIT] &&
              !s.con2[CON2_STOP_EN_BIT]) begin
            next_s.shbuf = i_pwdata[REG_W-1:0];
            next_s.sreg = i_pwdata[REG_W-1:0];
            next_s.bf = 1'b1;
            next_s.bitcnt = 4'h0;
            next_s.scl_lo = 1'b1;
            next_s.sda_lo = ~i_pwdata[REG_W-1];
            brg_load = 1'b1;
            next_s.st = IMC_TX_LOW;
          end else begin
            next_s.con1[CON1_WCOL_BIT] = 1'b1;
          end
        end
        ADDR_CON1: begin
          next_s.con1 = i_pwdata[REG_W-1:0];
          // the write collision flag takes the written bit whether or not a sequence runs
          if (s.con1[CON1_WCOL_BIT] && busy && s.st != IMC_IDLE) begin
            next_s.con1[CON1_WCOL_BIT] = i_pwdata[CON1_WCOL_BIT];
          end
        end
        ADDR_CON2: next_s.con2 = i_pwdata[REG_W-1:0];
        ADDR_CON3: next_s.con3 = i_pwdata[REG_W-1:0];
        ADDR_MASK: next_s.mask = i_pwdata[REG_W-1:0];
        ADDR_STAT: next_s.stat_hi = i_pwdata[REG_W-1:STAT_HI_LSB];
        ADDR_COLL: begin
          if (i_pwdata[COLL_FLAG_BIT]) begin
            next_s.coll = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // port disabled mid-sequence: drop it and free the lines; an idle port keeps its line enables
    if (!enable && busy) begin
      next_s.st = IMC_IDLE;
      next_s.sda_lo = 1'b0;
      next_s.scl_lo = 1'b0;
      next_s.bf = 1'b0;
      brg_stop = 1'b1;
    end

    // collision last, so the flag set wins over a software clear
    if (abort) begin
      next_s.coll = 1'b1;
      next_s.st = IMC_IDLE;
      next_s.sda_lo = 1'b0;
      next_s.scl_lo = 1'b0;
      next_s.con2[CON2_RESTART_EN_BIT] = 1'b0;
      next_s.con2[CON2_STOP_EN_BIT] = 1'b0;
      brg_stop = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs
  assign o_prdata = s.rdata;
  assign o_pready = acc;
  assign o_pslverr = acc && !mapped;
  assign o_scl = 1'b0;
  assign o_scl_oe = s.scl_lo;
  assign o_sda = 1'b0;
  assign o_sda_oe = s.sda_lo;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_rs_clock_high;
    s.st == IMC_RS_SCL_REL && scl;
  endsequence

  sequence s_abort_done;
    s.st == IMC_IDLE && s.coll && !s.sda_lo && !s.scl_lo;
  endsequence

  property p_rs_data_low;
    s_rs_clock_high and (!sda) |=> s_abort_done;
  endproperty
  a_rs_data_low: assert property (p_rs_data_low)
    else $error("repeated start missed a low data sample");

  property p_rs_free_clock;
    (s.st == IMC_RS_WAIT1) |-> s.scl_lo && !s.sda_lo;
  endproperty
  a_rs_free_clock: assert property (p_rs_free_clock)
    else $error("clock released before the first count ended");

  property p_rs_data_high;
    s_rs_clock_high and (sda) |=> s.st == IMC_RS_WAIT2 && brg_running;
  endproperty
  a_rs_data_high: assert property (p_rs_data_high)
    else $error("repeated start did not reload on high data");

  property p_rs_data_fall_ok;
    (s.st == IMC_RS_WAIT2 && scl && !sda && !brg_expire) |=> !s.coll ||
      $past(s.coll);
  endproperty
  a_rs_data_fall_ok: assert property (p_rs_data_fall_ok)
    else $error("data fall taken as a collision");

  property p_rs_clock_fall;
    (s.st == IMC_RS_WAIT2 && !scl) |=> s_abort_done;
  endproperty
  a_rs_clock_fall: assert property (p_rs_clock_fall)
    else $error("early clock fall not flagged");

  property p_rs_drive_data;
    (s.st == IMC_RS_WAIT2 && scl && sda && brg_expire) |=>
      s.sda_lo && s.st == IMC_RS_WAIT3 && brg_running;
  endproperty
  a_rs_drive_data: assert property (p_rs_drive_data)
    else $error("data not driven low at expiry");

  property p_rs_finish;
    (s.st == IMC_RS_WAIT3 && brg_expire) |=>
      s.scl_lo && s.st == IMC_IDLE && !s.con2[CON2_RESTART_EN_BIT];
  endproperty
  a_rs_finish: assert property (p_rs_finish)
    else $error("repeated start did not finish with clock low");

  property p_stop_free_clock;
    (s.st == IMC_ST_SDA_LOW && !sda) |=> !s.scl_lo && s.sda_lo;
  endproperty
  a_stop_free_clock: assert property (p_stop_free_clock)
    else $error("stop did not free the clock");

  property p_stop_data_low;
    (s.st == IMC_ST_WAIT2 && scl && brg_expire && !sda) |=> s_abort_done;
  endproperty
  a_stop_data_low: assert property (p_stop_data_low)
    else $error("stop missed data held low");

  property p_stop_clock_low;
    (s.st == IMC_ST_WAIT2 && !scl && !sda) |=> s_abort_done;
  endproperty
  a_stop_clock_low: assert property (p_stop_clock_low)
    else $error("stop missed an early clock low");

  property p_stop_clock_early;
    (s.st == IMC_ST_WAIT1 && !scl) |=> s_abort_done;
  endproperty
  a_stop_clock_early: assert property (p_stop_clock_early)
    else $error("stop missed a clock low before data release");

  property p_abort_clears;
    $rose(s.coll) |-> !s.con2[CON2_RESTART_EN_BIT] &&
      !s.con2[CON2_STOP_EN_BIT] && !brg_running;
  endproperty
  a_abort_clears: assert property (p_abort_clears)
    else $error("collision left an enable bit set");

endmodule
`default_nettype wire

// File: imc_bus_model.sv
// far side of the port: pull-ups, other masters, a slow slave
// assumes the port's enables are high while it pulls a line low
`timescale 1ns/1ps
`default_nettype none
module imc_bus_model (
  input wire logic i_core_clk,
  input wire logic i_scl_oe,
  input wire logic i_sda_oe,
  input wire logic i_grab_scl,
  input wire logic i_grab_sda,
  input wire logic [7:0] i_stretch,
  output logic o_scl,
  output logic o_sda
);
  // ==========================================================================
  // clock stretch
  logic [7:0] hold = 8'h00;
  // keeps the clock low for a while after the port lets it go
  always @(posedge i_core_clk) begin
    if (i_scl_oe) begin
      hold <= i_stretch;
    end else if (hold != 8'h00) begin
      hold <= hold - 8'h01;
    end
  end
  // ==========================================================================
  // wired-and lines; a released line floats high
  assign o_scl = ~(i_scl_oe | i_grab_scl | (hold != 8'h00));
  assign o_sda = ~(i_sda_oe | i_grab_sda);
endmodule
`default_nettype wire

// File: test_i2c_master_collision_and_brg.sv
// testbench of the port: apb master, bus model, expected values from rules
// assumes imc_pkg, imc_port and imc_bus_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_i2c_master_collision_and_brg;
  import imc_pkg::*;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic scl_w, sda_w, scl_oe, sda_oe, grab_scl, grab_sda, err, scl_o, sda_o;
  logic [7:0] stretch, rl, b;
  logic exp_q[$];
  int miscompares = 0;
  int comparisons = 0;
  int seed = 32'hEE84;
  int n, t;

  imc_port imc_port_i (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_scl(scl_w), .o_scl(scl_o), .o_scl_oe(scl_oe),
    .i_sda(sda_w), .o_sda(sda_o), .o_sda_oe(sda_oe));
  imc_bus_model imc_bus_model_i (.i_core_clk(core_clk), .i_scl_oe(scl_oe),
    .i_sda_oe(sda_oe), .i_grab_scl(grab_scl), .i_grab_sda(grab_sda),
    .i_stretch(stretch), .o_scl(scl_w), .o_sda(sda_w));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // ==========================================================================
  // reporting
  task test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ==========================================================================
  // bus cycles and waits
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) miscompares++;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, WORD_ZERO);
    chk("read", e, q & m);
  endtask

  function logic pick(input int s);
    pick = (s == 0) ? scl_oe : (s == 1) ? sda_oe : scl_w;
  endfunction

  // counts edges until the chosen signal shows the level v
  task wt(input int s, input logic v, output int c);
    c = 0;
    while (pick(s) !== v && c < 4000) begin
      @(posedge core_clk);
      c++;
    end
    if (c >= 4000) chk("wait", 32'h1, 32'h0);
  endtask

  task poll(input logic [7:0] m);
    int k;
    k = 0;
    do begin
      apb(1'b0, ADDR_CON2, WORD_ZERO);
      k++;
    end while ((q[7:0] & m) != 8'h00 && k < 300);
    chk("seq_bits", 32'h0, q & {24'h000000, m});
  endtask

  task gap(input int c);
    chk("gap", 32'h1, {31'h0, (c > t && c <= t + 5)});
  endtask

  // disturbs the bus at a chosen point of a sequence
  task coll(input logic [7:0] cmd, input int s, input bit two, input int dly,
            input bit on_scl, input logic e, input logic [1:0] eoe);
    apb(1'b1, ADDR_CON2, {24'h000000, cmd});
    wt(s, 1'b1, n);
    if (two) wt(s, 1'b0, n);
    repeat (dly) @(posedge core_clk);
    if (on_scl) grab_scl <= 1'b1;
    else grab_sda <= 1'b1;
    poll(cmd);
    chk("oe_end", {30'h0, eoe}, {30'h0, scl_oe, sda_oe});
    grab_scl <= 1'b0;
    grab_sda <= 1'b0;
    rd(ADDR_COLL, 32'h3, {31'h0, e});
    apb(1'b1, ADDR_COLL, 32'h00000001);
    rd(ADDR_COLL, 32'h1, 32'h0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = WORD_ZERO;
    grab_scl = 1'b0;
    grab_sda = 1'b0;
    stretch = 8'h00;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 8'(i * 4), WORD_ZERO);
      chk("reset_val", WORD_ZERO, q);
      chk("slverr", {31'h0, i == 8}, {31'h0, err});
    end
    // reload kept above the unsupported values
    rl = 8'(8 + {$random(seed)} % 8);
    t = 2 * (int'(rl) + 1);
    b = 8'($random(seed));
    apb(1'b1, ADDR_CON3, 32'($random(seed)));
    apb(1'b1, ADDR_MASK, 32'(~b));
    apb(1'b1, ADDR_RELOAD, {24'h00FFFF, rl});
    rd(ADDR_MASK, 32'hFFFFFFFF, {24'h000000, ~b});
    rd(ADDR_RELOAD, 32'hFFFFFFFF, {24'h000000, rl});
    apb(1'b1, ADDR_SHBUF, {24'h000000, b});
    rd(ADDR_CON1, 32'hFF, 32'h80);
    rd(ADDR_SHBUF, 32'hFF, 32'h0);
    apb(1'b1, ADDR_CON1, 32'h00000020);
    rd(ADDR_CON1, 32'hFF, 32'h20);
    for (int k = 7; k >= 0; k--) exp_q.push_back(b[k]);
    apb(1'b1, ADDR_SHBUF, {24'h000000, b});
    wt(0, 1'b1, n);
    for (int k = 0; k < 8; k++) begin
      wt(0, 1'b0, n);
      if (k > 0) chk("low_phase", t, n);
      chk("bit", {31'h0, exp_q.pop_front()}, {31'h0, ~sda_oe});
      if (k < 7) wt(0, 1'b1, n);
      if (k < 7) chk("high_phase", t, n);
    end
    repeat (3 * t) @(posedge core_clk);
    chk("hold_level", 32'h0, {30'h0, scl_oe, sda_oe});
    rd(ADDR_STAT, 32'h01, 32'h0);
    stretch <= 8'h07;
    apb(1'b1, ADDR_CON2, 32'h00000002);
    wt(0, 1'b1, n);
    wt(0, 1'b0, n);
    wt(2, 1'b1, n);
    wt(1, 1'b1, n);
    gap(n);
    poll(8'h02);
    chk("rs_clock_low", 32'h1, {31'h0, scl_oe});
    chk("pin_low", 32'h0, {30'h0, scl_o, sda_o});
    rd(ADDR_STAT, 32'h08, 32'h08);
    rd(ADDR_COLL, 32'h1, 32'h0);
    apb(1'b1, ADDR_CON2, 32'h00000004);
    wt(0, 1'b0, n);
    wt(2, 1'b1, n);
    wt(1, 1'b0, n);
    gap(n);
    poll(8'h04);
    rd(ADDR_STAT, 32'h10, 32'h10);
    chk("stop_lines", 32'h0, {30'h0, scl_oe, sda_oe});
    // a stretched clock lets the data grab settle before the clock rises
    coll(8'h02, 0, 1'b1, 0, 1'b0, 1'b1, 2'b00);
    stretch <= 8'h00;
    coll(8'h02, 0, 1'b1, 6, 1'b1, 1'b1, 2'b00);
    coll(8'h04, 1, 1'b1, 0, 1'b0, 1'b1, 2'b00);
    coll(8'h04, 1, 1'b0, 8, 1'b1, 1'b1, 2'b00);
    coll(8'h02, 0, 1'b1, 6, 1'b0, 1'b0, 2'b11);
    test_done;
  end

  // ==========================================================================
  // watchdog
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    test_done;
  end
endmodule
`default_nettype wire
